/* File: rim_alias_map.sv */
`timescale 1ns/1ps
`include "rim_consts.svh"

// What this block does
// RULE1 - Override set stops forward loads of control
// RULE2 - Override clear lets forward data load control
// RULE3 - GPIO count codes give none, one, two, four
// RULE4 - GPIO count writable locally only under override
// RULE5 - Serializer address auto-loads from forward channel
// RULE6 - Address lock keeps software-written serializer address
// RULE7 - Serializer alias match marks remote transaction
// RULE8 - Zero serializer alias disables that decode
// RULE9 - Auto-ack acknowledges every remote serializer write
// RULE10 - Target zero alias remapped to physical address
// RULE11 - Target one alias remapped to physical address
// RULE12 - Separate register copy per port, selected
// RULE13 - Forward only while port pass-through enabled
// RULE14 - Reserved bits read zero, writes ignored
module rim_alias_map
  import rim_pkg::*;
#(
  parameter int NPORTS = 4
)(
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  // Local register port from the I2C target engine
  input  wire logic                              reg_wr_i,
  input  wire logic                              reg_rd_i,
  input  wire rim_pkg::rim_byte_t                reg_addr_i,
  input  wire rim_pkg::rim_byte_t                reg_wdata_i,
  output rim_pkg::rim_byte_t                     reg_rdata_o,
  output logic                                   reg_rvalid_o,
  // Forward channel loads, one strobe per port
  input  wire logic [NPORTS-1:0]                 fc_load_i,
  input  wire logic [NPORTS-1:0][1:0]            fc_gpio_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  fc_remote_ser_address_i,
  // Per-port pass-through enable and target aliases from elsewhere
  input  wire logic [NPORTS-1:0]                 pass_en_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt0_alias_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt1_alias_i,
  // Local I2C address decode request
  input  wire logic                              dec_valid_i,
  input  wire logic                              dec_write_i,
  input  wire rim_pkg::rim_addr7_t               dec_addr_i,
  // Decode result towards the control channel
  output logic                                   fwd_valid_o,
  output rim_pkg::rim_hit_e                      fwd_kind_o,
  output logic [1:0]                             fwd_port_o,
  output rim_pkg::rim_addr7_t                    fwd_addr_o,
  output logic                                   fwd_autoack_o,
  // Forward GPIO enables per port
  output logic [NPORTS-1:0][3:0]                 gpio_en_o
);
  import rim_pkg::*;

  // Port select reset byte, cut to the two bits that are kept
  localparam rim_byte_t RST_PSEL = `RIM_RST_PORT_SEL;

  // Port select holds two bits, so at most four ports can be reached
  if (NPORTS < 1 || NPORTS > 4) begin : g_bad_nports
    $error("NPORTS must be 1 to 4");
  end

  // Port select register, low bits pick the bank
  logic [1:0]  port_sel_reg;
  // Per-port register state gathered from the banks
  rim_byte_t   bank_rd      [NPORTS];
  logic        bank_override[NPORTS];
  logic [NPORTS-1:0][1:0] bank_gpio;
  rim_addr7_t [NPORTS-1:0] bank_ser_addr;
  rim_addr7_t [NPORTS-1:0] bank_alias;
  rim_addr7_t [NPORTS-1:0] bank_tgt0;
  rim_addr7_t [NPORTS-1:0] bank_tgt1;
  logic [NPORTS-1:0] bank_autoack;
  logic [NPORTS-1:0] bank_lock;
  // Combinational decoder result
  rim_hit_e    dec_kind;
  logic [1:0]  dec_port;
  rim_addr7_t  dec_map;
  logic        dec_pass;

  // Port select register write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_sel_reg <= RST_PSEL[`RIM_PSEL_HI:0];
    end else if (reg_wr_i && reg_addr_i == `RIM_OFS_PORT_SEL) begin
      port_sel_reg <= reg_wdata_i[`RIM_PSEL_HI:0]; // see RULE12
    end
  end

  // One bank per receive port; only the selected one takes a write
  for (genvar p = 0; p < NPORTS; p++) begin : g_bank
    rim_port_bank u_bank (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .wr_en_i      (reg_wr_i && port_sel_reg == 2'(p)), // see RULE12
      .wr_addr_i    (reg_addr_i),
      .wr_data_i    (reg_wdata_i),
      .rd_addr_i    (reg_addr_i),
      .rd_data_o    (bank_rd[p]),
      .fc_load_i    (fc_load_i[p]),
      .fc_gpio_i    (fc_gpio_i[p]),
      .fc_remote_ser_address_i  (fc_remote_ser_address_i[p]),
      .override_o   (bank_override[p]),
      .gpio_count_o (bank_gpio[p]),
      .ser_addr_o   (bank_ser_addr[p]),
      .lock_o       (bank_lock[p]),
      .ser_alias_o  (bank_alias[p]),
      .autoack_o    (bank_autoack[p]),
      .tgt0_o       (bank_tgt0[p]),
      .tgt1_o       (bank_tgt1[p])
    );
  end

  // Read data lands one cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (!reg_rd_i) begin
        reg_rdata_o <= reg_rdata_o;
      end else if (reg_addr_i == `RIM_OFS_PORT_SEL) begin
        reg_rdata_o <= {6'h00, port_sel_reg};
      end else begin
        reg_rdata_o <= bank_rd[port_sel_reg]; // see RULE12
      end
    end
  end

  // Alias decoder across every port
  rim_alias_decode #(
    .NPORTS (NPORTS)
  ) u_decode (
    .addr_i       (dec_addr_i),
    .ser_alias_i  (bank_alias),
    .ser_addr_i   (bank_ser_addr),
    .tgt0_alias_i (tgt0_alias_i),
    .tgt1_alias_i (tgt1_alias_i),
    .tgt0_i       (bank_tgt0),
    .tgt1_i       (bank_tgt1),
    .kind_o       (dec_kind),
    .port_o       (dec_port),
    .addr_o       (dec_map)
  );

  // A hit only goes out while its port passes traffic through
  assign dec_pass = pass_en_i[dec_port];

  // Registered decode result; kind, port and address held until the next request, valid and auto-ack clear after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_valid_o   <= 1'b0;
      fwd_kind_o    <= RIM_HIT_NONE;
      fwd_port_o    <= 2'h0;
      fwd_addr_o    <= 7'h00;
      fwd_autoack_o <= 1'b0;
    end else if (dec_valid_i) begin
      fwd_valid_o   <= dec_kind != RIM_HIT_NONE && dec_pass; // see RULE13
      fwd_kind_o    <= dec_kind;
      fwd_port_o    <= dec_port;
      fwd_addr_o    <= dec_map; // see RULE10 see RULE11
      // Auto-ack ignores lock state and the remote acknowledge
      fwd_autoack_o <= dec_kind == RIM_HIT_SER && dec_write_i &&
                       bank_autoack[dec_port]; // see RULE9
    end else begin
      fwd_valid_o   <= 1'b0;
      fwd_autoack_o <= 1'b0;
    end
  end

  // Forward GPIO enables follow each port's count code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_en_o <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        gpio_en_o[p] <= rim_gpio_decode(bank_gpio[p]); // see RULE3
      end
    end
  end

  // Request and its one-cycle answer
  sequence s_ser_write;
    dec_valid_i && dec_write_i && dec_kind == RIM_HIT_SER;
  endsequence

  sequence s_ser_autoack_answer;
    ##1 fwd_autoack_o && fwd_kind_o == RIM_HIT_SER;
  endsequence

  a_gpio_decode: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE3
    ##1 gpio_en_o[0] == rim_gpio_decode($past(bank_gpio[0])))
    else $error("gpio enable mask does not follow count");

  a_ser_alias_hit: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE7
    dec_valid_i && bank_alias[0] != 7'h00 && dec_addr_i == bank_alias[0]
    |=> fwd_kind_o == RIM_HIT_SER && fwd_addr_o == $past(bank_ser_addr[0]))
    else $error("serializer alias match not forwarded");

  a_alias_zero_off: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE8
    dec_valid_i && dec_addr_i == 7'h00 |=> fwd_kind_o != RIM_HIT_SER)
    else $error("zero alias decoded as serializer");

  a_autoack_write: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE9
    s_ser_write and bank_autoack[dec_port] |-> s_ser_autoack_answer)
    else $error("remote serializer write not auto acknowledged");

  a_tgt0_remap: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE10
    dec_valid_i && dec_kind == RIM_HIT_T0
    |=> fwd_addr_o == $past(bank_tgt0[dec_port]))
    else $error("target zero address not remapped");

  a_tgt1_remap: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE11
    dec_valid_i && dec_kind == RIM_HIT_T1
    |=> fwd_addr_o == $past(bank_tgt1[dec_port]))
    else $error("target one address not remapped");

  a_port_select: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE12
    reg_rd_i && reg_addr_i != `RIM_OFS_PORT_SEL
    |=> reg_rvalid_o && reg_rdata_o == $past(bank_rd[port_sel_reg]))
    else $error("read not from selected port bank");

  a_pass_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE13
    dec_valid_i && !dec_pass |=> !fwd_valid_o)
    else $error("forwarded while pass-through disabled");

endmodule

/* File: rim_consts.svh */
`ifndef RIM_CONSTS_SVH
`define RIM_CONSTS_SVH

// Register offsets on the local register port
`define RIM_OFS_PORT_SEL      8'h4C
`define RIM_OFS_FWD_CTL       8'h59
`define RIM_OFS_FWD_SPARE     8'h5A
`define RIM_OFS_SER_ADDR      8'h5B
`define RIM_OFS_SER_ALIAS     8'h5C
`define RIM_OFS_TGT0          8'h5D
`define RIM_OFS_TGT1          8'h5E

// Field positions
`define RIM_BIT_OVERRIDE      7
`define RIM_BIT_LOCK          0
`define RIM_BIT_AUTOACK       0
`define RIM_ADDR_HI           7
`define RIM_ADDR_LO           1
`define RIM_GPIO_HI           1
`define RIM_GPIO_LO           0
`define RIM_PSEL_HI           1

// Reset values
`define RIM_RST_FWD_CTL       8'h00
`define RIM_RST_SER_ADDR      8'h00
`define RIM_RST_SER_ALIAS     8'h00
`define RIM_RST_TGT           8'h00
`define RIM_RST_PORT_SEL      8'h00

// Alias value that switches a decode off
`define RIM_ALIAS_OFF         7'h00

// Latency of the registered forwarding result, in cycles
`define RIM_FWD_LATENCY       1

`endif

/* File: rim_pkg.sv */
package rim_pkg;

  // Seven-bit I2C address
  typedef logic [6:0] rim_addr7_t;

  // Register data byte
  typedef logic [7:0] rim_byte_t;

  // Kind of decode hit for a local I2C address
  typedef enum logic [1:0] {
    RIM_HIT_NONE = 2'b00,
    RIM_HIT_SER  = 2'b01,
    RIM_HIT_T0   = 2'b10,
    RIM_HIT_T1   = 2'b11
  } rim_hit_e;

  // Forward GPIO count code to a thermometer enable mask
  function automatic logic [3:0] rim_gpio_decode(input logic [1:0] code);
    logic [3:0] m;
    m = 4'h0;
    unique case (code)
      2'b00: m = 4'h0; // see RULE3
      2'b01: m = 4'h1;
      2'b10: m = 4'h3;
      2'b11: m = 4'hF;
    endcase
    return m;
  endfunction

endpackage

/* File: rim_port_bank.sv */
`timescale 1ns/1ps
`include "rim_consts.svh"

module rim_port_bank
  import rim_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Local write port, already gated by port select
  input  wire logic              wr_en_i,
  input  wire rim_pkg::rim_byte_t wr_addr_i,
  input  wire rim_pkg::rim_byte_t wr_data_i,
  // Read address, combinational data back
  input  wire rim_pkg::rim_byte_t rd_addr_i,
  output rim_pkg::rim_byte_t     rd_data_o,
  // Forward channel load from the remote serializer
  input  wire logic              fc_load_i,
  input  wire logic [1:0]        fc_gpio_i,
  input  wire rim_pkg::rim_addr7_t fc_remote_ser_address_i,
  // Register state to the decoder
  output logic                   override_o,
  output logic [1:0]             gpio_count_o,
  output rim_pkg::rim_addr7_t    ser_addr_o,
  output logic                   lock_o,
  output rim_pkg::rim_addr7_t    ser_alias_o,
  output logic                   autoack_o,
  output rim_pkg::rim_addr7_t    tgt0_o,
  output rim_pkg::rim_addr7_t    tgt1_o
);
  import rim_pkg::*;

  // Reset bytes, taken apart into fields by part-select
  localparam rim_byte_t RST_CTL   = `RIM_RST_FWD_CTL;
  localparam rim_byte_t RST_SER   = `RIM_RST_SER_ADDR;
  localparam rim_byte_t RST_ALIAS = `RIM_RST_SER_ALIAS;
  localparam rim_byte_t RST_TGT   = `RIM_RST_TGT;

  logic wr_ctl;   // Write hits forward path control
  logic wr_ser;   // Write hits serializer address
  assign wr_ctl = wr_en_i && (wr_addr_i == `RIM_OFS_FWD_CTL);
  assign wr_ser = wr_en_i && (wr_addr_i == `RIM_OFS_SER_ADDR);

  // Override bit: always writable locally
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      override_o <= RST_CTL[`RIM_BIT_OVERRIDE];
    end else if (wr_ctl) begin
      override_o <= wr_data_i[`RIM_BIT_OVERRIDE];
    end
  end

  // GPIO count: local write only under override, else forward channel
  // Local write beats a same-cycle load so software is never undone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gpio_count_o <= 2'h0;
    end else if (wr_ctl && override_o) begin
      gpio_count_o <= wr_data_i[`RIM_GPIO_HI:`RIM_GPIO_LO]; // see RULE4
    end else if (fc_load_i && !override_o) begin
      gpio_count_o <= fc_gpio_i; // see RULE2
    end // Override set: forward data dropped, see RULE1
  end

  // Serializer address and lock bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_addr_o <= RST_SER[`RIM_ADDR_HI:`RIM_ADDR_LO];
      lock_o     <= RST_SER[`RIM_BIT_LOCK];
    end else if (wr_ser) begin
      ser_addr_o <= wr_data_i[`RIM_ADDR_HI:`RIM_ADDR_LO];
      lock_o     <= wr_data_i[`RIM_BIT_LOCK];
    end else if (fc_load_i && !lock_o) begin
      ser_addr_o <= fc_remote_ser_address_i; // see RULE5 see RULE6
    end
  end

  // Alias, auto-ack and target physical addresses: plain storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ser_alias_o <= RST_ALIAS[`RIM_ADDR_HI:`RIM_ADDR_LO];
      autoack_o   <= RST_ALIAS[`RIM_BIT_AUTOACK];
      tgt0_o      <= RST_TGT[`RIM_ADDR_HI:`RIM_ADDR_LO];
      tgt1_o      <= RST_TGT[`RIM_ADDR_HI:`RIM_ADDR_LO];
    end else if (wr_en_i) begin
      unique case (wr_addr_i)
        `RIM_OFS_SER_ALIAS: begin
          ser_alias_o <= wr_data_i[`RIM_ADDR_HI:`RIM_ADDR_LO];
          autoack_o   <= wr_data_i[`RIM_BIT_AUTOACK];
        end
        `RIM_OFS_TGT0: tgt0_o <= wr_data_i[`RIM_ADDR_HI:`RIM_ADDR_LO];
        `RIM_OFS_TGT1: tgt1_o <= wr_data_i[`RIM_ADDR_HI:`RIM_ADDR_LO];
        default: ; // Spare and reserved bits ignored, see RULE14
      endcase
    end
  end

  // Read mux; reserved bits and the spare register read zero
  always_comb begin
    rd_data_o = 8'h00;
    unique case (rd_addr_i)
      `RIM_OFS_FWD_CTL:   rd_data_o = {override_o, 5'h00, gpio_count_o};
      `RIM_OFS_SER_ADDR:  rd_data_o = {ser_addr_o, lock_o};
      `RIM_OFS_SER_ALIAS: rd_data_o = {ser_alias_o, autoack_o};
      `RIM_OFS_TGT0:      rd_data_o = {tgt0_o, 1'b0};
      `RIM_OFS_TGT1:      rd_data_o = {tgt1_o, 1'b0};
      default:            rd_data_o = 8'h00; // see RULE14
    endcase
  end

  a_override_blocks: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE1
    fc_load_i && override_o && !wr_ctl |=> $stable(gpio_count_o))
    else $error("forward load changed gpio count under override");

  a_fc_loads_gpio: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE2
    fc_load_i && !override_o && !wr_ctl |=> gpio_count_o == $past(fc_gpio_i))
    else $error("forward load did not reach gpio count");

  a_gpio_write_gate: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE4
    wr_ctl && !override_o && !fc_load_i |=> $stable(gpio_count_o))
    else $error("gpio count written without override");

  a_id_autoload: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE5
    fc_load_i && !lock_o && !wr_ser |=> ser_addr_o == $past(fc_remote_ser_address_i))
    else $error("serializer address not auto loaded");

  a_id_locked: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE6
    (lock_o && !wr_ser) [*2] |-> $stable(ser_addr_o))
    else $error("locked serializer address changed");

  a_spare_zero: assert property (@(posedge clk_i) disable iff (rst_i) // see RULE14
    rd_addr_i == `RIM_OFS_FWD_SPARE |-> rd_data_o == 8'h00)
    else $error("spare register read nonzero");

endmodule

/* File: rim_alias_decode.sv */
`timescale 1ns/1ps
`include "rim_consts.svh"

module rim_alias_decode
  import rim_pkg::*;
#(
  parameter int NPORTS = 4
)(
  // Address under decode
  input  wire rim_pkg::rim_addr7_t               addr_i,
  // Per-port alias and mapping state
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  ser_alias_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  ser_addr_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt0_alias_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt1_alias_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt0_i,
  input  wire rim_pkg::rim_addr7_t [NPORTS-1:0]  tgt1_i,
  // Result
  output rim_pkg::rim_hit_e                      kind_o,
  output logic [1:0]                             port_o,
  output rim_pkg::rim_addr7_t                    addr_o
);
  import rim_pkg::*;

  // Lowest port wins when two ports carry the same alias; software
  // should keep aliases unique, this only makes the outcome defined
  always_comb begin
    kind_o = RIM_HIT_NONE;
    port_o = 2'h0;
    addr_o = 7'h00;
    for (int p = NPORTS - 1; p >= 0; p--) begin
      if (ser_alias_i[p] != `RIM_ALIAS_OFF && addr_i == ser_alias_i[p]) begin
        kind_o = RIM_HIT_SER; // see RULE7 see RULE8
        port_o = 2'(p);
        addr_o = ser_addr_i[p];
      end else if (tgt0_alias_i[p] != `RIM_ALIAS_OFF &&
                   addr_i == tgt0_alias_i[p]) begin
        kind_o = RIM_HIT_T0;
        port_o = 2'(p);
        addr_o = tgt0_i[p]; // see RULE10
      end else if (tgt1_alias_i[p] != `RIM_ALIAS_OFF &&
                   addr_i == tgt1_alias_i[p]) begin
        kind_o = RIM_HIT_T1;
        port_o = 2'(p);
        addr_o = tgt1_i[p]; // see RULE11
      end
    end
  end

endmodule

/* File: rim_ser_model.sv */
`timescale 1ns/1ps
// Remote serializer side of the forward channel: pushes its GPIO
// count and its own ID to one receive port with a one-cycle strobe
module rim_ser_model
  import rim_pkg::*;
(
  // Clock
  input  wire logic                 clk_i,
  // Forward channel toward the hub
  output logic [3:0]                fc_load_o,
  output logic [3:0][1:0]           fc_gpio_o,
  output rim_pkg::rim_addr7_t [3:0] fc_remote_ser_address_o
);
  import rim_pkg::*;

  // Quiet channel at time zero
  initial begin
    fc_load_o   = '0;
    fc_gpio_o   = '0;
    fc_remote_ser_address_o = '0;
  end

  // One frame after a stall of idle cycles, so slow links are covered
  task automatic send(input logic [1:0] port, input logic [1:0] gpio,
                      input rim_addr7_t id, input int stall);
    repeat (stall) @(negedge clk_i);
    @(negedge clk_i);
    fc_load_o[port]   = 1'b1;
    fc_gpio_o[port]   = gpio;
    fc_remote_ser_address_o[port] = id;
    @(negedge clk_i);
    // Released lines flip so a stale value can never be read as valid
    fc_load_o[port]   = 1'b0;
    fc_gpio_o[port]   = ~gpio;
    fc_remote_ser_address_o[port] = ~id;
  endtask
endmodule

/* File: rim_alias_map_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the per-port alias map
module rim_alias_map_test;
  import rim_pkg::*;

  // Far above the roughly 130 cycles the tests need
  localparam int WD_CYCLES = 3000;

  // Design signals
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             reg_wr, reg_rd, rvalid;
  rim_byte_t        reg_addr, reg_wdata, rdata;
  logic [3:0]       fc_load;
  logic [3:0][1:0]  fc_gpio;
  rim_addr7_t [3:0] fc_id, t0_alias, t1_alias;
  logic [3:0]       pass_en;
  logic             dec_valid, dec_write, fwd_valid, fwd_autoack;
  rim_addr7_t       dec_addr, fwd_addr;
  rim_hit_e         fwd_kind;
  logic [1:0]       fwd_port;
  logic [3:0][3:0]  gpio_en;
  int               fails = 0;
  int               check_count = 0;
  // Expected enable masks for count codes 0 to 3
  logic [3:0]       gmask [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
  // Rows: offset, write data, read back; bank 0 selected at start
  rim_byte_t        ra [9] = '{8'h59, 8'h59, 8'h5A, 8'h5B, 8'h5C,
                               8'h5D, 8'h5E, 8'h10, 8'h4C};
  rim_byte_t        rw [9] = '{8'h83, 8'h83, 8'hFF, 8'h45, 8'h45,
                               8'hFF, 8'h33, 8'hFF, 8'hFF};
  rim_byte_t        re [9] = '{8'h80, 8'h83, 8'h00, 8'h45, 8'h45,
                               8'hFE, 8'h32, 8'h00, 8'h03};

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  rim_alias_map #(.NPORTS(4)) u_rim_alias_map (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .fc_load_i(fc_load), .fc_gpio_i(fc_gpio),
    .fc_remote_ser_address_i(fc_id), .pass_en_i(pass_en), .tgt0_alias_i(t0_alias),
    .tgt1_alias_i(t1_alias), .dec_valid_i(dec_valid),
    .dec_write_i(dec_write), .dec_addr_i(dec_addr),
    .fwd_valid_o(fwd_valid), .fwd_kind_o(fwd_kind),
    .fwd_port_o(fwd_port), .fwd_addr_o(fwd_addr),
    .fwd_autoack_o(fwd_autoack), .gpio_en_o(gpio_en));

  rim_ser_model u_rim_ser_model (
    .clk_i(clk_i), .fc_load_o(fc_load), .fc_gpio_o(fc_gpio),
    .fc_remote_ser_address_o(fc_id));

  // One comparison, counted
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Register write, one strobe cycle
  task automatic wr(input rim_byte_t a, input rim_byte_t d);
    @(negedge clk_i);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_i);
    reg_wr    = 1'b0;
  endtask

  // Register read; data comes with the valid pulse a cycle later
  task automatic rd(input rim_byte_t a, input rim_byte_t e);
    @(negedge clk_i);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk_i);
    reg_rd   = 1'b0;
    chk({7'h00, rvalid}, 8'h01, "read valid");
    chk(rdata, e, "read data");
  endtask

  // Decode request and check of the registered result
  task automatic dec(input rim_addr7_t a, input logic w, input logic ev,
                     input rim_hit_e ek, input logic [1:0] ep,
                     input rim_addr7_t ea, input logic eack);
    @(negedge clk_i);
    dec_valid = 1'b1;
    dec_write = w;
    dec_addr  = a;
    @(negedge clk_i);
    dec_valid = 1'b0;
    chk({7'h00, fwd_valid}, {7'h00, ev}, "forward valid");
    chk({6'h00, fwd_kind}, {6'h00, ek}, "hit kind");
    chk({7'h00, fwd_autoack}, {7'h00, eack}, "auto ack");
    // Port and address only mean something on a hit
    if (ek != RIM_HIT_NONE) begin
      chk({6'h00, fwd_port}, {6'h00, ep}, "hit port");
      chk({1'b0, fwd_addr}, {1'b0, ea}, "mapped address");
    end
  endtask

  // Verdict and end of run
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = '0;
    reg_wdata   = '0;
    dec_valid   = 1'b0;
    dec_write   = 1'b0;
    dec_addr    = '0;
    pass_en     = 4'b0100;
    t0_alias    = '0;
    t1_alias    = '0;
    t0_alias[2] = 7'h31;
    t1_alias[2] = 7'h32;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    // Reset state of outputs and of bank 0 plus port select
    chk({6'h00, fwd_kind}, 8'h00, "kind after reset");
    chk({gpio_en[1], gpio_en[0]}, 8'h00, "masks after reset");
    for (int i = 0; i < 7; i++) begin
      rd((i == 0) ? 8'h4C : rim_byte_t'(8'h58 + i), 8'h00);
    end
    $display("Test reset values done");
    // Ordinary register rows
    for (int i = 0; i < 9; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], re[i]);
    end
    $display("Test register rows done");
    // Bank 1 is separate and starts clear
    wr(8'h4C, 8'h01);
    rd(8'h59, 8'h00);
    for (int c = 0; c < 4; c++) begin
      u_rim_ser_model.send(2'd1, c[1:0], 7'h2A, c);
      @(negedge clk_i);
      chk({4'h0, gpio_en[1]}, {4'h0, gmask[c]}, "gpio mask");
    end
    rd(8'h59, 8'h03);
    rd(8'h5B, 8'h54);
    // Count write ignored until the stored override is set
    wr(8'h59, 8'h80);
    rd(8'h59, 8'h83);
    wr(8'h59, 8'h81);
    rd(8'h59, 8'h81);
    u_rim_ser_model.send(2'd1, 2'd2, 7'h2B, 0);
    rd(8'h59, 8'h81);
    rd(8'h5B, 8'h56);
    wr(8'h5B, 8'h11);
    u_rim_ser_model.send(2'd1, 2'd0, 7'h55, 0);
    rd(8'h5B, 8'h11);
    $display("Test forward loads done");
    // Bank 2 mapping: ser 0x1E, alias 0x30 with auto ack, targets
    wr(8'h4C, 8'h02);
    wr(8'h5B, 8'h3C);
    wr(8'h5C, 8'h61);
    wr(8'h5D, 8'hA0);
    wr(8'h5E, 8'hA4);
    dec(7'h30, 1'b1, 1'b1, RIM_HIT_SER, 2'd2, 7'h1E, 1'b1);
    dec(7'h30, 1'b0, 1'b1, RIM_HIT_SER, 2'd2, 7'h1E, 1'b0);
    dec(7'h31, 1'b1, 1'b1, RIM_HIT_T0, 2'd2, 7'h50, 1'b0);
    dec(7'h32, 1'b0, 1'b1, RIM_HIT_T1, 2'd2, 7'h52, 1'b0);
    dec(7'h00, 1'b1, 1'b0, RIM_HIT_NONE, 2'd0, 7'h00, 1'b0);
    dec(7'h7F, 1'b1, 1'b0, RIM_HIT_NONE, 2'd0, 7'h00, 1'b0);
    // Port 0 alias 0x22 hits but its pass-through is off
    dec(7'h22, 1'b0, 1'b0, RIM_HIT_SER, 2'd0, 7'h22, 1'b0);
    pass_en = 4'b0000;
    dec(7'h31, 1'b0, 1'b0, RIM_HIT_T0, 2'd2, 7'h50, 1'b0);
    $display("Test decode done");
    final_report();
  end

  // Watchdog against a hang
  initial begin
    repeat (WD_CYCLES) @(posedge clk_i);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
